// >>> sdpcf_chk_assertions.sv
// concurrent checks on the pins joining the sdram front end and its controller
`timescale 1ns/1ns
module sdpcf_chk_assertions (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    // watched pins
    input wire logic cke,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic [sdpcf_pkg::SDPCF_LANES-1:0] dqm,
    input wire logic [sdpcf_pkg::SDPCF_LANES-1:0] dq_dev_oe_b
);
    import sdpcf_pkg::*;
    logic [3:0] cmd;
    logic [3:0] since_rd_ff;
    logic [2:0] low_run_ff;
    assign cmd = {cs_b, ras_b, cas_b, we_b};
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_B_IN);
    // saturates so a stale read never looks recent
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) since_rd_ff <= 4'hF;
        else if (cmd == SDPCF_CMD_RD && cke) since_rd_ff <= 4'h1;
        else if (since_rd_ff != 4'hF) since_rd_ff <= since_rd_ff + 4'h1;
    end
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN || dq_dev_oe_b[0]) low_run_ff <= 3'h0;
        else if (low_run_ff != 3'h7) low_run_ff <= low_run_ff + 3'h1;
    end
    sequence rd_recent;
        since_rd_ff >= 4'h2 && since_rd_ff <= 4'h7;
    endsequence
    sequence cke_held_low;
        !cke [*3];
    endsequence
    chk_mrd_gap_kept: assert property (cmd == SDPCF_CMD_LMR && cke |=>
        cmd != SDPCF_CMD_ACT && cmd != SDPCF_CMD_REF) else $error("activate too soon after mode load");
    chk_rrd_gap_kept: assert property (cmd == SDPCF_CMD_ACT && cke |=> cmd != SDPCF_CMD_ACT)
        else $error("activates too close");
    chk_lane0_mask_float: assert property (dqm[0] |-> ##[2:3] dq_dev_oe_b[0])
        else $error("lane 0 driven while masked");
    chk_lane3_mask_float: assert property (dqm[3] |-> ##[2:3] dq_dev_oe_b[3])
        else $error("lane 3 driven while masked");
    chk_lane0_read_origin: assert property ($fell(dq_dev_oe_b[0]) |-> rd_recent)
        else $error("lane 0 driven without read");
    chk_lane3_read_origin: assert property ($fell(dq_dev_oe_b[3]) |-> rd_recent)
        else $error("lane 3 driven without read");
    chk_burst_four_beats: assert property (low_run_ff <= 3'h4)
        else $error("read burst longer than four beats");
    chk_gated_output_hold: assert property (cke_held_low |=> $stable(dq_dev_oe_b))
        else $error("output enables moved while clock gated");
endmodule : sdpcf_chk_assertions

// >>> sdpcf_ctl.sv
// controller end: drives command pins, keeps mode-load and activate spacing, flags when a refresh is due
`timescale 1ns/1ns
module sdpcf_ctl (
    // system clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    // pins
    sdpcf_if.ctl PINS,
    // user request
    input wire logic REQ_VALID_IN,
    input wire logic [3:0] REQ_CMD_IN,
    input wire logic [sdpcf_pkg::SDPCF_BANK_W-1:0] REQ_BA_IN,
    input wire logic [sdpcf_pkg::SDPCF_ADDR_W-1:0] REQ_ADDR_IN,
    input wire logic [sdpcf_pkg::SDPCF_LANES-1:0] REQ_DQM_IN,
    input wire logic [sdpcf_pkg::SDPCF_DQ_W-1:0] REQ_WDATA_IN,
    input wire logic REQ_DRIVE_IN,
    input wire logic CKE_IN,
    output logic REQ_READY_OUT,
    // status
    output logic REF_DUE_OUT,
    output logic [sdpcf_pkg::SDPCF_DQ_W-1:0] RDATA_OUT
);
    import sdpcf_pkg::*;

    logic [1:0] mrd_cnt_ff;
    logic [1:0] rrd_cnt_ff;
    logic [31:0] ref_cnt_ff;
    logic [3:0] cmd_ff;
    logic [SDPCF_BANK_W-1:0] ba_ff;
    logic [SDPCF_ADDR_W-1:0] addr_ff;
    logic [SDPCF_LANES-1:0] dqm_ff;
    logic [SDPCF_DQ_W-1:0] wd_ff;
    logic [SDPCF_LANES-1:0] oe_b_ff;
    logic cke_ff;
    logic [SDPCF_DQ_W-1:0] rd_s1_ff, rd_s2_ff;
    logic blocked;
    logic take;

    // mode load blocks activate and refresh; activates blocked by spacing
    assign blocked = ((mrd_cnt_ff != 2'h0) &&
                      (REQ_CMD_IN == SDPCF_CMD_ACT || REQ_CMD_IN == SDPCF_CMD_REF)) ||
                     ((rrd_cnt_ff != 2'h0) && REQ_CMD_IN == SDPCF_CMD_ACT);
    assign REQ_READY_OUT = !blocked;
    assign take = REQ_VALID_IN && !blocked;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            mrd_cnt_ff <= 2'h0;
            rrd_cnt_ff <= 2'h0;
        end else begin
            if (take && REQ_CMD_IN == SDPCF_CMD_LMR) begin
                mrd_cnt_ff <= 2'(SDPCF_MRD_CK - 1);
            end else if (mrd_cnt_ff != 2'h0) begin
                mrd_cnt_ff <= mrd_cnt_ff - 2'h1;
            end
            if (take && REQ_CMD_IN == SDPCF_CMD_ACT) begin
                rrd_cnt_ff <= 2'(SDPCF_RRD_CK - 1);
            end else if (rrd_cnt_ff != 2'h0) begin
                rrd_cnt_ff <= rrd_cnt_ff - 2'h1;
            end
        end
    end

    // refresh interval tracker; flag set wins over clearing refresh
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            ref_cnt_ff <= 32'h0;
            REF_DUE_OUT <= 1'b0;
        end else if (ref_cnt_ff == 32'(SDPCF_REF_GAP_CK - 1)) begin
            ref_cnt_ff <= 32'h0;
            REF_DUE_OUT <= 1'b1;
        end else begin
            ref_cnt_ff <= ref_cnt_ff + 32'h1;
            if (take && REQ_CMD_IN == SDPCF_CMD_REF) begin
                REF_DUE_OUT <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            cmd_ff <= SDPCF_CMD_INHIBIT;
            ba_ff <= '0;
            addr_ff <= '0;
            dqm_ff <= '1;
            wd_ff <= '0;
            oe_b_ff <= '1;
            cke_ff <= 1'b0;
        end else begin
            cke_ff <= CKE_IN;
            cmd_ff <= take ? REQ_CMD_IN : SDPCF_CMD_NOP;
            ba_ff <= REQ_BA_IN;
            addr_ff <= REQ_ADDR_IN;
            dqm_ff <= REQ_DQM_IN;
            wd_ff <= REQ_WDATA_IN;
            oe_b_ff <= {SDPCF_LANES{!REQ_DRIVE_IN}};
        end
    end

    // read data bus comes from the other chip; resample twice
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            rd_s1_ff <= '0;
            rd_s2_ff <= '0;
        end else begin
            rd_s1_ff <= PINS.dq;
            rd_s2_ff <= rd_s1_ff;
        end
    end

    assign RDATA_OUT = rd_s2_ff;
    assign PINS.cke = cke_ff;
    assign PINS.cs_b = cmd_ff[3];
    assign PINS.ras_b = cmd_ff[2];
    assign PINS.cas_b = cmd_ff[1];
    assign PINS.we_b = cmd_ff[0];
    assign PINS.ba = ba_ff;
    assign PINS.addr = addr_ff;
    assign PINS.dqm = dqm_ff;
    assign PINS.dq_ctl_out = wd_ff;
    assign PINS.dq_ctl_oe_b = oe_b_ff;
endmodule : sdpcf_ctl

// >>> sdpcf_dev.sv
// device end: registered pin capture, command decode, bank state, power states, dq lanes
`timescale 1ns/1ns
// Summary of operation
// - all inputs captured on rising clock edge
// - clock steps burst counter and output registers
// - low clock enable picks power or suspend
// - clock enable asynchronous-like inside power states
// - receivers disabled during power-down, self refresh
// - registered high chip select masks command
// - command decoded from four strobes
// - masked write lanes are not stored
// - read mask floats lane two cycles later
// - sixteen-bit: lower mask governs low byte
// - thirty-two-bit: mask n governs byte n
// - bank inputs pick bank, ignored all-precharge
// - address row on activate, column on access
// - precharge bit ten high means all banks
// - mode register loads from address inputs
// - controller waits two cycles after mode load
// - controller spaces activates by two cycles
// - controller flags a refresh due every 1562 cycles, 4096 per 64 ms; the user issues them
module sdpcf_dev (
    // system clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    // pins
    sdpcf_if.dev PINS,
    // memory array side
    output logic WR_EN_OUT,
    output logic [sdpcf_pkg::SDPCF_LANES-1:0] WR_BE_OUT,
    output logic [sdpcf_pkg::SDPCF_BANK_W-1:0] MEM_BANK_OUT,
    output logic [sdpcf_pkg::SDPCF_ADDR_W-1:0] MEM_ROW_OUT,
    output logic [sdpcf_pkg::SDPCF_COL_W-1:0] MEM_COL_OUT,
    output logic [sdpcf_pkg::SDPCF_DQ_W-1:0] WR_DATA_OUT,
    input wire logic [sdpcf_pkg::SDPCF_DQ_W-1:0] RD_DATA_IN,
    // status
    output logic [sdpcf_pkg::SDPCF_ADDR_W-1:0] MODE_OUT,
    output logic [sdpcf_pkg::SDPCF_BANKS-1:0] BANK_OPEN_OUT,
    output sdpcf_pkg::sdpcf_pm_t PM_STATE_OUT,
    output logic RX_EN_OUT,
    output logic REFRESH_OUT
);
    import sdpcf_pkg::*;

    function automatic sdpcf_op_t decode_op(input logic [3:0] c);
        sdpcf_op_t op;
        op = SDPCF_OP_NONE;
        if (!c[3]) begin
            case (c)
                SDPCF_CMD_NOP: op = SDPCF_OP_NOP;
                SDPCF_CMD_ACT: op = SDPCF_OP_ACT;
                SDPCF_CMD_RD: op = SDPCF_OP_RD;
                SDPCF_CMD_WR: op = SDPCF_OP_WR;
                SDPCF_CMD_BST: op = SDPCF_OP_BST;
                SDPCF_CMD_PRE: op = SDPCF_OP_PRE;
                SDPCF_CMD_REF: op = SDPCF_OP_REF;
                SDPCF_CMD_LMR: op = SDPCF_OP_LMR;
                default: op = SDPCF_OP_NONE;
            endcase
        end
        return op;
    endfunction : decode_op

    logic cke_s1_ff, cke_s2_ff, cke_q_ff;
    logic [3:0] cmd_ff;
    logic [SDPCF_BANK_W-1:0] ba_ff;
    logic [SDPCF_ADDR_W-1:0] addr_ff;
    logic [SDPCF_LANES-1:0] dqm_ff;
    logic [SDPCF_DQ_W-1:0] dq_in_ff;
    logic [SDPCF_BANKS-1:0] open_ff;
    logic [SDPCF_ADDR_W-1:0] row_ff [SDPCF_BANKS];
    logic [SDPCF_ADDR_W-1:0] mode_ff;
    sdpcf_pm_t pm_ff, nxt_pm;
    logic burst_rd_ff, burst_wr_ff;
    logic [2:0] burst_cnt_ff;
    logic [SDPCF_COL_W-1:0] col_ff;
    logic [SDPCF_BANK_W-1:0] bank_ff;
    // the pin capture flop is the first stage of the float delay
    logic [SDPCF_LANES-1:0] dqz_pipe_ff [SDPCF_DQZ_LAT-1];
    logic [SDPCF_DQ_W-1:0] dq_out_ff;
    logic rd_live_ff;
    logic [SDPCF_LANES-1:0] oe_b_ff;
    logic clk_en;
    logic rx_en;
    sdpcf_op_t op;
    logic ap_ff;
    logic burst_end;
    logic [SDPCF_DQ_W-1:0] wr_data_ff;
    logic [SDPCF_LANES-1:0] wr_mask_ff;

    // receivers off in power states; only the clock enable path stays alive
    assign rx_en = (pm_ff == SDPCF_PM_RUN) || (pm_ff == SDPCF_PM_SUSPEND);
    assign clk_en = cke_q_ff && (pm_ff == SDPCF_PM_RUN);
    assign op = clk_en ? decode_op(cmd_ff) : SDPCF_OP_NONE;

    // clock enable passes a two-stage synchroniser, it may move while the clock is gated
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            cke_s1_ff <= 1'b0;
            cke_s2_ff <= 1'b0;
            cke_q_ff <= 1'b0;
        end else begin
            cke_s1_ff <= PINS.cke;
            cke_s2_ff <= cke_s1_ff;
            cke_q_ff <= cke_s2_ff;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            cmd_ff <= SDPCF_CMD_INHIBIT;
            ba_ff <= '0;
            addr_ff <= '0;
            dqm_ff <= '1;
            dq_in_ff <= '0;
        end else if (rx_en && cke_s2_ff) begin
            cmd_ff <= {PINS.cs_b, PINS.ras_b, PINS.cas_b, PINS.we_b};
            ba_ff <= PINS.ba;
            addr_ff <= PINS.addr;
            dqm_ff <= PINS.dqm;
            dq_in_ff <= PINS.dq;
        end else begin
            cmd_ff <= SDPCF_CMD_INHIBIT;
        end
    end

    // bank open state and row latch
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            open_ff <= '0;
            for (int b = 0; b < SDPCF_BANKS; b++) begin
                row_ff[b] <= '0;
            end
        end else if (op == SDPCF_OP_ACT) begin
            open_ff[ba_ff] <= 1'b1;
            row_ff[ba_ff] <= addr_ff;
        end else if (op == SDPCF_OP_PRE) begin
            if (addr_ff[SDPCF_AP_BIT]) begin
                open_ff <= '0;
            end else begin
                open_ff[ba_ff] <= 1'b0;
            end
        end else if (burst_end && ap_ff) begin
            open_ff[bank_ff] <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            mode_ff <= '0;
        end else if (op == SDPCF_OP_LMR) begin
            mode_ff <= addr_ff;
        end
    end

    // burst engine: fixed burst of four, auto precharge closes bank at end
    assign burst_end = clk_en && (burst_rd_ff || burst_wr_ff) &&
                       (burst_cnt_ff == SDPCF_BURST_LEN - 3'h1);
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            burst_rd_ff <= 1'b0;
            burst_wr_ff <= 1'b0;
            burst_cnt_ff <= '0;
            col_ff <= '0;
            bank_ff <= '0;
            ap_ff <= 1'b0;
        end else if (op == SDPCF_OP_RD || op == SDPCF_OP_WR) begin
            burst_rd_ff <= (op == SDPCF_OP_RD);
            burst_wr_ff <= (op == SDPCF_OP_WR);
            burst_cnt_ff <= '0;
            col_ff <= addr_ff[SDPCF_COL_W-1:0];
            bank_ff <= ba_ff;
            ap_ff <= addr_ff[SDPCF_AP_BIT];
        end else if (op == SDPCF_OP_BST || op == SDPCF_OP_PRE || burst_end) begin
            burst_rd_ff <= 1'b0;
            burst_wr_ff <= 1'b0;
            ap_ff <= 1'b0;
        end else if (clk_en && (burst_rd_ff || burst_wr_ff)) begin
            burst_cnt_ff <= burst_cnt_ff + 3'h1;
            col_ff <= col_ff + SDPCF_COL_W'(1);
        end
    end

    // power state choice from bank and burst state when clock enable falls
    always_comb begin
        nxt_pm = pm_ff;
        case (pm_ff)
            SDPCF_PM_RUN: begin
                if (!cke_s2_ff) begin
                    if (burst_rd_ff || burst_wr_ff) begin
                        nxt_pm = SDPCF_PM_SUSPEND;
                    end else if (|open_ff) begin
                        nxt_pm = SDPCF_PM_ACT_PD;
                    end else if (op == SDPCF_OP_REF || decode_op(cmd_ff) == SDPCF_OP_REF) begin
                        nxt_pm = SDPCF_PM_SELF_REF;
                    end else begin
                        nxt_pm = SDPCF_PM_PRE_PD;
                    end
                end
            end
            SDPCF_PM_PRE_PD, SDPCF_PM_ACT_PD, SDPCF_PM_SELF_REF, SDPCF_PM_SUSPEND: begin
                if (cke_s2_ff) begin
                    nxt_pm = SDPCF_PM_RUN;
                end
            end
            default: nxt_pm = SDPCF_PM_RUN;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            pm_ff <= SDPCF_PM_RUN;
        end else begin
            pm_ff <= nxt_pm;
        end
    end

    // read mask delay line; lanes handled per byte for both widths
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            for (int s = 0; s < SDPCF_DQZ_LAT-1; s++) begin
                dqz_pipe_ff[s] <= '1;
            end
            dq_out_ff <= '0;
            rd_live_ff <= 1'b0;
            oe_b_ff <= '1;
        end else if (clk_en) begin
            dqz_pipe_ff[0] <= dqm_ff;
            for (int s = 1; s < SDPCF_DQZ_LAT-1; s++) begin
                dqz_pipe_ff[s] <= dqz_pipe_ff[s-1];
            end
            rd_live_ff <= burst_rd_ff;
            dq_out_ff <= RD_DATA_IN;
            for (int l = 0; l < SDPCF_LANES; l++) begin
                oe_b_ff[l] <= !(rd_live_ff && !dqz_pipe_ff[SDPCF_DQZ_LAT-2][l]);
            end
        end
    end

    // write beat stage: data and mask sampled with the command line up with the first beat
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_B_IN) begin
            wr_data_ff <= '0;
            wr_mask_ff <= '1;
        end else if (clk_en) begin
            wr_data_ff <= dq_in_ff;
            wr_mask_ff <= dqm_ff;
        end
    end

    assign WR_EN_OUT = clk_en && burst_wr_ff;
    assign WR_BE_OUT = ~wr_mask_ff;
    assign WR_DATA_OUT = wr_data_ff;
    assign MEM_BANK_OUT = bank_ff;
    assign MEM_ROW_OUT = row_ff[bank_ff];
    assign MEM_COL_OUT = col_ff;
    assign MODE_OUT = mode_ff;
    assign BANK_OPEN_OUT = open_ff;
    assign PM_STATE_OUT = pm_ff;
    assign RX_EN_OUT = rx_en;
    assign REFRESH_OUT = (op == SDPCF_OP_REF);
    assign PINS.dq_dev_out = dq_out_ff;
    assign PINS.dq_dev_oe_b = oe_b_ff;
endmodule : sdpcf_dev

// >>> sdpcf_if.sv
// pin bundle between the sdram front end and its controller
`timescale 1ns/1ns
interface sdpcf_if;
    import sdpcf_pkg::*;
    logic cke;
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [SDPCF_BANK_W-1:0] ba;
    logic [SDPCF_ADDR_W-1:0] addr;
    logic [SDPCF_LANES-1:0] dqm;
    logic [SDPCF_DQ_W-1:0] dq_ctl_out;
    logic [SDPCF_LANES-1:0] dq_ctl_oe_b;
    logic [SDPCF_DQ_W-1:0] dq_dev_out;
    logic [SDPCF_LANES-1:0] dq_dev_oe_b;
    logic [SDPCF_DQ_W-1:0] dq;
    always_comb begin
        for (int i = 0; i < SDPCF_LANES; i++) begin
            if (!dq_dev_oe_b[i]) begin
                dq[i*8 +: 8] = dq_dev_out[i*8 +: 8];
            end else if (!dq_ctl_oe_b[i]) begin
                dq[i*8 +: 8] = dq_ctl_out[i*8 +: 8];
            end else begin
                dq[i*8 +: 8] = 8'h00;
            end
        end
    end
    modport dev (input cke, cs_b, ras_b, cas_b, we_b, ba, addr, dqm, dq,
                 output dq_dev_out, dq_dev_oe_b);
    modport ctl (output cke, cs_b, ras_b, cas_b, we_b, ba, addr, dqm, dq_ctl_out,
                 dq_ctl_oe_b, input dq);
endinterface : sdpcf_if

// >>> sdpcf_pkg.sv
// shared constants and types for the sdram pin and command front end
package sdpcf_pkg;
    localparam int SDPCF_DQ_W = 32;
    localparam int SDPCF_LANES = 4;
    localparam int SDPCF_ADDR_W = 12;
    localparam int SDPCF_BANK_W = 2;
    localparam int SDPCF_BANKS = 4;
    localparam int SDPCF_AP_BIT = 10;
    localparam int SDPCF_COL_W = 8;
    localparam int SDPCF_DQZ_LAT = 2;
    localparam int SDPCF_MRD_CK = 2;
    localparam int SDPCF_RRD_CK = 2;
    localparam int SDPCF_REF_CMDS = 4096;
    localparam int SDPCF_REF_MS = 64;
    localparam int SDPCF_CLK_MHZ = 100;
    localparam longint SDPCF_REF_WIN_CK = 64'(SDPCF_REF_MS) * 1000 * SDPCF_CLK_MHZ;
    localparam int SDPCF_REF_GAP_CK = int'(SDPCF_REF_WIN_CK / SDPCF_REF_CMDS);
    localparam logic [3:0] SDPCF_CMD_INHIBIT = 4'h8;
    localparam logic [3:0] SDPCF_CMD_NOP = 4'h7;
    localparam logic [3:0] SDPCF_CMD_ACT = 4'h3;
    localparam logic [3:0] SDPCF_CMD_RD = 4'h5;
    localparam logic [3:0] SDPCF_CMD_WR = 4'h4;
    localparam logic [3:0] SDPCF_CMD_BST = 4'h6;
    localparam logic [3:0] SDPCF_CMD_PRE = 4'h2;
    localparam logic [3:0] SDPCF_CMD_REF = 4'h1;
    localparam logic [3:0] SDPCF_CMD_LMR = 4'h0;
    localparam logic [2:0] SDPCF_BURST_LEN = 3'h4;
    typedef enum logic [3:0] {
        SDPCF_OP_NONE, SDPCF_OP_NOP, SDPCF_OP_ACT, SDPCF_OP_RD, SDPCF_OP_WR,
        SDPCF_OP_BST, SDPCF_OP_PRE, SDPCF_OP_REF, SDPCF_OP_LMR
    } sdpcf_op_t;
    typedef enum logic [2:0] {
        SDPCF_PM_RUN, SDPCF_PM_PRE_PD, SDPCF_PM_ACT_PD, SDPCF_PM_SELF_REF, SDPCF_PM_SUSPEND
    } sdpcf_pm_t;
endpackage : sdpcf_pkg

// >>> sdram_pin_command_frontend_bench.sv
// self-checking bench joining the sdram device end and controller end
`timescale 1ns/1ns
module sdram_pin_command_frontend_bench;
    import sdpcf_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic [3:0] req_cmd = SDPCF_CMD_NOP;
    logic [1:0] req_ba = 2'h0;
    logic [11:0] req_addr = 12'h000;
    logic [3:0] req_dqm = 4'h0;
    logic req_drive = 1'b0;
    logic cke_in = 1'b0;
    logic req_ready, ref_due, wr_en, rx_en, refresh;
    logic [3:0] wr_be, bank_open;
    logic [1:0] mem_bank;
    logic [11:0] mem_row, mode;
    logic [7:0] mem_col;
    logic [31:0] wr_data, rdata;
    sdpcf_pm_t pm_state;
    int err_total = 0;
    int tests_run = 0;
    int beats0, beats3, ref_pulses;
    logic [7:0] dq0_seen;
    logic rdata_hit;
    sdpcf_if pins_if();
    sdpcf_dev sdpcf_dev_i (.CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b), .PINS(pins_if),
        .WR_EN_OUT(wr_en), .WR_BE_OUT(wr_be), .MEM_BANK_OUT(mem_bank), .MEM_ROW_OUT(mem_row),
        .MEM_COL_OUT(mem_col), .WR_DATA_OUT(wr_data), .RD_DATA_IN(32'h5A6B7C8D),
        .MODE_OUT(mode), .BANK_OPEN_OUT(bank_open), .PM_STATE_OUT(pm_state),
        .RX_EN_OUT(rx_en), .REFRESH_OUT(refresh));
    sdpcf_ctl sdpcf_ctl_i (.CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b), .PINS(pins_if),
        .REQ_VALID_IN(req_valid), .REQ_CMD_IN(req_cmd), .REQ_BA_IN(req_ba),
        .REQ_ADDR_IN(req_addr), .REQ_DQM_IN(req_dqm), .REQ_WDATA_IN(32'hA1B2C3D4),
        .REQ_DRIVE_IN(req_drive), .CKE_IN(cke_in), .REQ_READY_OUT(req_ready),
        .REF_DUE_OUT(ref_due), .RDATA_OUT(rdata));
    sdpcf_chk_assertions sdpcf_chk_assertions_i (.CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b),
        .cke(pins_if.cke), .cs_b(pins_if.cs_b), .ras_b(pins_if.ras_b), .cas_b(pins_if.cas_b),
        .we_b(pins_if.we_b), .dqm(pins_if.dqm), .dq_dev_oe_b(pins_if.dq_dev_oe_b));
    always #5 clk_sys = ~clk_sys;
    // sampled mid-cycle, where pins and pulses have settled
    always @(negedge clk_sys) begin
        if (pins_if.dq_dev_oe_b[0] === 1'b0) beats0++;
        if (pins_if.dq_dev_oe_b[0] === 1'b0) dq0_seen = pins_if.dq[7:0];
        if (pins_if.dq_dev_oe_b[3] === 1'b0) beats3++;
        if (rdata[7:0] === 8'h8D) rdata_hit = 1'b1;
        if (refresh === 1'b1) ref_pulses++;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_n
    // leaves the request up; caller must issue again or idle at once
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
        input logic [3:0] m, output int waited);
        waited = 0;
        req_valid = 1'b1;
        req_cmd = c;
        req_ba = b;
        req_addr = a;
        req_dqm = m;
        #1;
        while (req_ready !== 1'b1) begin
            waited++;
            if (waited > 20) begin
                err_total++;
                conclude();
            end
            @(negedge clk_sys);
            #1;
        end
        @(negedge clk_sys);
    endtask : issue
    task automatic idle();
        req_valid = 1'b0;
        req_cmd = SDPCF_CMD_NOP;
        req_drive = 1'b0;
        req_dqm = 4'h0;
    endtask : idle
    task automatic t_setup();
        int w;
        check("pm_run", 32'(pm_state), 32'(SDPCF_PM_RUN));
        issue(SDPCF_CMD_LMR, 2'h0, 12'h032, 4'h0, w);
        issue(SDPCF_CMD_ACT, 2'h2, 12'hABC, 4'h0, w);
        check("mrd_wait", 32'(w), 32'h1);
        issue(SDPCF_CMD_ACT, 2'h1, 12'h123, 4'h0, w);
        check("rrd_wait", 32'(w), 32'h1);
        idle();
        wait_n(4);
        check("mode", 32'(mode), 32'h032);
        check("open", 32'(bank_open), 32'h6);
    endtask : t_setup
    task automatic t_write();
        int w;
        int n;
        req_drive = 1'b1;
        issue(SDPCF_CMD_WR, 2'h2, 12'h015, 4'h4, w);
        idle();
        // clock enable drops while the burst runs: clock suspend
        cke_in = 1'b0;
        for (n = 0; n < 12 && wr_en !== 1'b1; n++) @(negedge clk_sys);
        check("wr_seen", 32'(wr_en), 32'h1);
        check("wr_be", 32'(wr_be), 32'hB);
        check("wr_bank", 32'(mem_bank), 32'h2);
        check("wr_row", 32'(mem_row), 32'hABC);
        check("wr_col", 32'(mem_col), 32'h15);
        check("wr_data", wr_data, 32'hA1B2C3D4);
        wait_n(4);
        check("suspend", 32'(pm_state), 32'(SDPCF_PM_SUSPEND));
        check("rx_kept", 32'(rx_en), 32'h1);
        cke_in = 1'b1;
        wait_n(8);
        check("susp_exit", 32'(pm_state), 32'(SDPCF_PM_RUN));
    endtask : t_write
    task automatic t_read();
        int w;
        beats0 = 0;
        beats3 = 0;
        rdata_hit = 1'b0;
        issue(SDPCF_CMD_RD, 2'h1, 12'h440, 4'h0, w);
        // lane 3 masked from the next cycle on, past the whole burst
        repeat (5) issue(SDPCF_CMD_NOP, 2'h0, 12'h000, 4'h8, w);
        idle();
        wait_n(8);
        check("beats0", 32'(beats0), 32'h4);
        check("beats3", 32'(beats3), 32'h0);
        check("dq0", 32'(dq0_seen), 32'h8D);
        check("rdata", 32'(rdata_hit), 32'h1);
        // lane 0 masked for one sample only, so only the first beat floats
        beats0 = 0;
        beats3 = 0;
        issue(SDPCF_CMD_RD, 2'h2, 12'h020, 4'h0, w);
        issue(SDPCF_CMD_NOP, 2'h0, 12'h000, 4'h1, w);
        idle();
        wait_n(8);
        check("beats0_one", 32'(beats0), 32'h3);
        check("beats3_all", 32'(beats3), 32'h4);
        check("auto_pre", 32'(bank_open), 32'h4);
    endtask : t_read
    task automatic t_precharge();
        int w;
        issue(4'hB, 2'h1, 12'h000, 4'h0, w);
        idle();
        wait_n(4);
        check("inhibit", 32'(bank_open), 32'h4);
        issue(SDPCF_CMD_ACT, 2'h0, 12'h001, 4'h0, w);
        issue(SDPCF_CMD_ACT, 2'h3, 12'h002, 4'h0, w);
        issue(SDPCF_CMD_PRE, 2'h3, 12'h000, 4'h0, w);
        idle();
        wait_n(4);
        check("pre_one", 32'(bank_open), 32'h5);
        issue(SDPCF_CMD_PRE, 2'h1, 12'h400, 4'h0, w);
        idle();
        wait_n(4);
        check("pre_all", 32'(bank_open), 32'h0);
    endtask : t_precharge
    task automatic t_power();
        int w;
        cke_in = 1'b0;
        wait_n(6);
        check("pre_pd", 32'(pm_state), 32'(SDPCF_PM_PRE_PD));
        check("rx_off", 32'(rx_en), 32'h0);
        cke_in = 1'b1;
        wait_n(6);
        check("pd_exit", 32'(pm_state), 32'(SDPCF_PM_RUN));
        issue(SDPCF_CMD_ACT, 2'h1, 12'h010, 4'h0, w);
        idle();
        wait_n(3);
        cke_in = 1'b0;
        wait_n(6);
        check("act_pd", 32'(pm_state), 32'(SDPCF_PM_ACT_PD));
        cke_in = 1'b1;
        wait_n(6);
        check("act_exit", 32'(pm_state), 32'(SDPCF_PM_RUN));
        issue(SDPCF_CMD_PRE, 2'h0, 12'h400, 4'h0, w);
        idle();
        wait_n(4);
    endtask : t_power
    task automatic t_refresh();
        int w;
        wait_n(SDPCF_REF_GAP_CK + 40);
        check("ref_due", 32'(ref_due), 32'h1);
        ref_pulses = 0;
        // clock enable falls as the refresh lands: self refresh entry
        cke_in = 1'b0;
        wait_n(1);
        issue(SDPCF_CMD_REF, 2'h0, 12'h000, 4'h0, w);
        idle();
        wait_n(5);
        check("ref_pulse", 32'(ref_pulses), 32'h1);
        check("ref_clear", 32'(ref_due), 32'h0);
        check("self_ref", 32'(pm_state), 32'(SDPCF_PM_SELF_REF));
        check("sr_rx_off", 32'(rx_en), 32'h0);
        cke_in = 1'b1;
        wait_n(6);
        check("sr_exit", 32'(pm_state), 32'(SDPCF_PM_RUN));
    endtask : t_refresh
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        cke_in = 1'b1;
        wait_n(8);
        t_setup();
        t_write();
        t_read();
        t_precharge();
        t_power();
        t_refresh();
        conclude();
    end
endmodule : sdram_pin_command_frontend_bench
